// File: rtl/noload_regs.svh
// Functional notes
// RQ1: Total-active no-load when active and apparent both idle; active accumulation and pulses stop.
// RQ2: Fundamental no-load when fundamental active and reactive both idle; both accumulations and pulses stop.
// RQ3: Each no-load threshold is an unsigned sixteen-bit value from its own register.
// RQ4: Filter-enable bit zero of third config register low bypasses all high-pass filters.
// RQ5: Total-active no-load shows on status bit 0 and phase bits 2..0, else zero.
// RQ6: Fundamental no-load shows on status bit 1 and phase bits 5..3, else zero.
// RQ7: Apparent flag, status bit 2, sets whenever any phase enters or leaves apparent no-load.
// RQ8: Interrupt pin goes low while apparent flag set and mask bit 2 set.
// RQ9: The apparent phase bit of the phase entering or leaving no-load toggles.
// RQ10: Writing one to status bit 2 clears the apparent flag and releases interrupt.
// RQ11: A phase contributes to a pulse output only while its term-select bit is set.
// RQ12: With read-reset bit 6 set, energy registers clear to zero when read.
// RQ13: Host zeroes reactive and active thresholds and relies on apparent interrupt only.
// RQ14: Host reads phase bits, adjusts term select, clears flag, flushes energies on exit.
// RQ15: Each phase keeps its own timers, restarted whenever the monitored energy accumulates.
`ifndef NOLOAD_REGS_SVH
`define NOLOAD_REGS_SVH
`define ST_TOT_BIT 0
`define ST_FUND_BIT 1
`define ST_APP_BIT 2
`define PH_TOT_LSB 0
`define PH_FUND_LSB 3
`define PH_APP_LSB 6
`define HPF_ON_BIT 0
`define RD_CLR_BIT 6
`define MASK_APP_BIT 2
`define TERMSEL_STRIDE 3
`define ACC_TOT 0
`define ACC_FACT 1
`define ACC_FREACT 2
`define CNT_ZERO 16'h0000
`define CNT_ONE 16'h0001
`define CNT_MAX 16'hffff
`endif

// File: rtl/noload_pkg.sv
package noload_pkg;
   typedef enum logic [1:0] {
      TK_TOT = 2'b00,
      TK_APP = 2'b01,
      TK_FACT = 2'b10,
      TK_FREACT = 2'b11
   } tmr_kind_e;
   typedef struct packed {
      logic [15:0] cnt;
      logic idle;
   } idle_timer_s;
endpackage : noload_pkg

// File: rtl/idle_tmr_if.sv
`timescale 1ns/10ps
interface idle_tmr_if;
   logic tick;
   logic [15:0] thresh;
   logic idle;
   modport owner (output tick, output thresh, input idle);
   modport timer (input tick, input thresh, output idle);
endinterface : idle_tmr_if

// File: rtl/idle_timer.sv
`timescale 1ns/10ps
`include "noload_regs.svh"
module idle_timer (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   idle_tmr_if.timer tif
);
   noload_pkg::idle_timer_s s_r;
   noload_pkg::idle_timer_s s_nxt;

   // A zero threshold never declares idle, so software can switch a detector off.
   always_comb begin
      s_nxt = s_r;
      if (tif.tick) begin
         s_nxt.cnt = `CNT_ZERO; // RQ15
         s_nxt.idle = 1'b0;
      end else begin
         if (s_r.cnt != `CNT_MAX) begin
            s_nxt.cnt = s_r.cnt + `CNT_ONE;
         end
         s_nxt.idle = (tif.thresh != `CNT_ZERO) && (s_r.cnt >= tif.thresh); // RQ3
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '0;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign tif.idle = s_r.idle;

   a_tick_restart: assert property (@(posedge sys_clk) disable iff (rst) // RQ15
      ce && tif.tick |=> s_r.cnt == `CNT_ZERO && !tif.idle)
      else $error("timer did not restart on accumulation");
   a_zero_thr_off: assert property (@(posedge sys_clk) disable iff (rst) // RQ3
      ce && tif.thresh == `CNT_ZERO |=> !tif.idle)
      else $error("zero threshold produced idle");
endmodule : idle_timer

// File: rtl/energy_noload_detect.sv
`timescale 1ns/10ps
`include "noload_regs.svh"
module energy_noload_detect #(
   parameter int ACC_W = 32
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [2:0] active_tick,
   input wire logic [2:0] apparent_tick,
   input wire logic [2:0] fund_active_tick,
   input wire logic [2:0] fund_reactive_tick,
   input wire logic [15:0] active_noload_threshold,
   input wire logic [15:0] apparent_noload_threshold,
   input wire logic [15:0] reactive_noload_threshold,
   input wire logic [7:0] third_config_reg,
   input wire logic [7:0] line_cycle_mode_reg,
   input wire logic [7:0] first_interrupt_mask_reg,
   input wire logic [8:0] computation_mode_reg,
   input wire logic first_status_wr,
   input wire logic [7:0] first_status_wdata,
   input wire logic energy_rd,
   output logic [2:0] first_status_reg,
   output logic [8:0] idle_phase_reg,
   output logic irq_n,
   output logic [2:0] pulse_output,
   output logic highpass_filter_on,
   output logic [2:0][2:0][ACC_W-1:0] energy_acc
);
   typedef struct packed {
      logic [2:0][2:0][ACC_W-1:0] acc;
      logic [8:0] phase_bits;
      logic [2:0] flags;
      logic irq_n;
      logic [2:0] pulse;
      logic hpf_on;
   } core_s;

   core_s s_r;
   core_s s_nxt;
   logic [3:0][2:0] ticks;
   logic [2:0][3:0] idle;
   logic [2:0] tot_idle;
   logic [2:0] fund_idle;
   logic [2:0] app_idle;
   logic [2:0][2:0] blocked;
   logic [2:0] app_change;
   logic rd_clear;

   assign ticks = {fund_reactive_tick, fund_active_tick, apparent_tick, active_tick};

   // One timer per phase and energy kind; each restarts on its own accumulation.
   for (genvar p = 0; p < 3; p++) begin : g_phase
      for (genvar k = 0; k < 4; k++) begin : g_kind
         idle_tmr_if tif ();
         assign tif.tick = ticks[k][p]; // RQ15
         assign tif.thresh = (k == noload_pkg::TK_APP) ? apparent_noload_threshold :
                             (k == noload_pkg::TK_FREACT) ? reactive_noload_threshold :
                             active_noload_threshold; // RQ3
         idle_timer u_tmr (
            .sys_clk(sys_clk),
            .rst(rst),
            .ce(ce),
            .tif(tif.timer)
         );
         assign idle[p][k] = tif.idle;
      end
      assign tot_idle[p] = idle[p][noload_pkg::TK_TOT] && idle[p][noload_pkg::TK_APP]; // RQ1
      assign fund_idle[p] = idle[p][noload_pkg::TK_FACT] && idle[p][noload_pkg::TK_FREACT]; // RQ2
      assign app_idle[p] = idle[p][noload_pkg::TK_APP];
      assign blocked[`ACC_TOT][p] = tot_idle[p]; // RQ1
      assign blocked[`ACC_FACT][p] = fund_idle[p]; // RQ2
      assign blocked[`ACC_FREACT][p] = fund_idle[p]; // RQ2
   end

   assign app_change = app_idle ^ s_r.phase_bits[`PH_APP_LSB +: 3];
   assign rd_clear = energy_rd && line_cycle_mode_reg[`RD_CLR_BIT];

   always_comb begin
      logic [2:0][2:0] acc_tick;
      logic clr;
      acc_tick = {fund_reactive_tick, fund_active_tick, active_tick};
      clr = first_status_wr && first_status_wdata[`ST_APP_BIT];
      s_nxt = s_r;
      for (int k = 0; k < 3; k++) begin
         for (int p = 0; p < 3; p++) begin
            // A quantum that lands in the read-clear cycle is kept, not lost.
            s_nxt.acc[k][p] = (rd_clear ? '0 : s_r.acc[k][p]) + // RQ12
                              ACC_W'(acc_tick[k][p] && !blocked[k][p]);
         end
         s_nxt.pulse[k] = |(acc_tick[k] & ~blocked[k] &
                            computation_mode_reg[k*`TERMSEL_STRIDE +: 3]); // RQ11
      end
      s_nxt.phase_bits[`PH_TOT_LSB +: 3] = tot_idle; // RQ5
      s_nxt.phase_bits[`PH_FUND_LSB +: 3] = fund_idle; // RQ6
      s_nxt.phase_bits[`PH_APP_LSB +: 3] = app_idle; // RQ9
      s_nxt.flags[`ST_TOT_BIT] = |tot_idle; // RQ5
      s_nxt.flags[`ST_FUND_BIT] = |fund_idle; // RQ6
      s_nxt.flags[`ST_APP_BIT] = (|app_change) || (s_r.flags[`ST_APP_BIT] && !clr); // RQ7 RQ10
      s_nxt.irq_n = !(s_nxt.flags[`ST_APP_BIT] && first_interrupt_mask_reg[`MASK_APP_BIT]); // RQ8
      s_nxt.hpf_on = third_config_reg[`HPF_ON_BIT]; // RQ4
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         s_r <= '0;
         s_r.irq_n <= 1'b1;
      end else if (ce) begin
         s_r <= s_nxt;
      end
   end

   assign first_status_reg = s_r.flags;
   assign idle_phase_reg = s_r.phase_bits;
   assign irq_n = s_r.irq_n;
   assign pulse_output = s_r.pulse;
   assign highpass_filter_on = s_r.hpf_on;
   assign energy_acc = s_r.acc;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   a_tot_blocked: assert property (ce && tot_idle[0] && !rd_clear |=> // RQ1
      energy_acc[`ACC_TOT][0] == $past(energy_acc[`ACC_TOT][0]))
      else $error("total active accumulated during no-load");
   a_fund_blocked: assert property (ce && fund_idle[1] && !rd_clear |=> // RQ2
      energy_acc[`ACC_FREACT][1] == $past(energy_acc[`ACC_FREACT][1]))
      else $error("fundamental reactive accumulated during no-load");
   // The reset edge itself is excluded, because the copy is forced to zero there.
   a_hpf_follow: assert property (!rst && ce |=> highpass_filter_on == $past(third_config_reg[`HPF_ON_BIT])) // RQ4
      else $error("filter enable not taken");
   a_tot_flag: assert property (first_status_reg[`ST_TOT_BIT] == |idle_phase_reg[`PH_TOT_LSB +: 3]) // RQ5
      else $error("total flag disagrees with phase bits");
   a_fund_flag: assert property (first_status_reg[`ST_FUND_BIT] == |idle_phase_reg[`PH_FUND_LSB +: 3]) // RQ6
      else $error("fundamental flag disagrees with phase bits");
   a_app_set: assert property (ce && (|app_change) |=> // RQ7
      first_status_reg[`ST_APP_BIT] && idle_phase_reg[`PH_APP_LSB +: 3] != $past(idle_phase_reg[`PH_APP_LSB +: 3]))
      else $error("apparent change did not set flag");
   a_irq_low: assert property (!irq_n |-> first_status_reg[`ST_APP_BIT]) // RQ8
      else $error("interrupt low without apparent flag");
   a_irq_on_set: assert property (ce && (|app_change) && first_interrupt_mask_reg[`MASK_APP_BIT] |=> !irq_n) // RQ8
      else $error("interrupt not raised");
   a_app_clear: assert property (ce && first_status_wr && first_status_wdata[`ST_APP_BIT] && !(|app_change) |=> // RQ10
      !first_status_reg[`ST_APP_BIT] && irq_n)
      else $error("write one did not clear flag");
   a_term_sel: assert property (ce && !computation_mode_reg[0] && !(|active_tick[2:1]) |=> !pulse_output[0]) // RQ11
      else $error("deselected phase produced a pulse");
   a_read_clear: assert property (ce && rd_clear && !active_tick[2] |=> energy_acc[`ACC_TOT][2] == '0) // RQ12
      else $error("read did not clear energy");

   c_app_event: cover property (ce && (|app_change));
   c_irq_low: cover property ($fell(irq_n));
   c_read_clear: cover property (ce && rd_clear);
   c_tot_idle: cover property ($rose(first_status_reg[`ST_TOT_BIT]));
endmodule : energy_noload_detect

// File: verif/noload_host.sv
`timescale 1ns/10ps
module noload_host #(
   parameter logic [15:0] APP_T = 16'h0008,
   parameter int WAIT_CYC = 0
) (
   input wire logic sys_clk,
   input wire logic irq_n,
   input wire logic [8:0] idle_phase_reg,
   output logic [15:0] active_noload_threshold,
   output logic [15:0] apparent_noload_threshold,
   output logic [15:0] reactive_noload_threshold,
   output logic [8:0] computation_mode_reg,
   output logic first_status_wr,
   output logic [7:0] first_status_wdata,
   output logic energy_rd
);
   logic [2:0] seen;
   logic [2:0] now;
   // Only the apparent detector is trusted, so the other two stay disabled.
   assign active_noload_threshold = 16'h0000;
   assign reactive_noload_threshold = 16'h0000;
   assign apparent_noload_threshold = APP_T;
   initial begin
      seen = 3'h0;
      computation_mode_reg = 9'h1ff;
      first_status_wr = 1'b0;
      first_status_wdata = 8'h00;
      energy_rd = 1'b0;
      forever begin
         @(posedge sys_clk);
         #1;
         if (irq_n === 1'b0) begin
            repeat (WAIT_CYC) @(posedge sys_clk);
            now = idle_phase_reg[8:6];
            for (int p = 0; p < 3; p++) begin
               if (now[p] != seen[p]) begin
                  {computation_mode_reg[p+6], computation_mode_reg[p+3], computation_mode_reg[p]} <= {3{~now[p]}};
               end
            end
            energy_rd <= |(seen & ~now);
            first_status_wr <= 1'b1;
            first_status_wdata <= 8'h04;
            seen = now;
            @(posedge sys_clk);
            first_status_wr <= 1'b0;
            first_status_wdata <= 8'h00;
            energy_rd <= 1'b0;
            @(posedge sys_clk);
         end
      end
   end
endmodule : noload_host

// File: verif/energy_noload_detect_tb_top.sv
`timescale 1ns/10ps
module energy_noload_detect_tb_top;
   localparam int app_t = 8;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [2:0] load = 3'h7;
   logic [2:0] tk = 3'h0;
   logic [7:0] cfg3 = 8'h01;
   logic tb_rd = 1'b0;
   logic host_rd, first_status_wr, irq_n, highpass_filter_on;
   logic [15:0] active_noload_threshold, apparent_noload_threshold, reactive_noload_threshold;
   logic [8:0] computation_mode_reg, idle_phase_reg;
   logic [7:0] first_status_wdata;
   logic [2:0] first_status_reg;
   logic [2:0] pulse_output;
   int pulses = 0;
   logic [2:0][2:0][31:0] energy_acc;
   int quiet [3] = '{0, 0, 0};
   int num_errors = 0;
   int compares = 0;
   always #2 sys_clk = ~sys_clk;
   energy_noload_detect DUT (.sys_clk, .rst, .ce(1'b1), .active_tick(tk), .apparent_tick(tk), .fund_active_tick(tk),
      .fund_reactive_tick(tk), .active_noload_threshold, .apparent_noload_threshold, .reactive_noload_threshold,
      .third_config_reg(cfg3), .line_cycle_mode_reg(8'h40), .first_interrupt_mask_reg(8'h04), .computation_mode_reg,
      .first_status_wr, .first_status_wdata, .energy_rd(host_rd | tb_rd), .first_status_reg, .idle_phase_reg,
      .irq_n, .pulse_output, .highpass_filter_on, .energy_acc);
   always @(posedge sys_clk) if (pulse_output[0] === 1'b1) pulses++;
   noload_host host (.sys_clk, .irq_n, .idle_phase_reg, .active_noload_threshold, .apparent_noload_threshold,
      .reactive_noload_threshold, .computation_mode_reg, .first_status_wr, .first_status_wdata, .energy_rd(host_rd));
   // A loaded phase never stays quiet longer than four cycles, well under the threshold.
   always @(posedge sys_clk) begin
      for (int p = 0; p < 3; p++) begin
         quiet[p] = tk[p] ? 0 : quiet[p] + 1;
         tk[p] <= load[p] && ((($urandom % 3) == 0) || quiet[p] >= 4);
      end
   end
   function automatic logic [2:0] idle_exp();
      for (int p = 0; p < 3; p++) idle_exp[p] = quiet[p] > app_t + 4;
   endfunction : idle_exp
   task chk(input logic [31:0] got, input logic [31:0] want, input string what);
      compares++;
      if (got !== want) begin
         num_errors++;
         $display("unexpected at %0t: %s is %h, expected %h", $time, what, got, want);
      end
   endtask : chk
   task end_sim;
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : end_sim
   task wait_n(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : wait_n
   task wait_irq;
      int n;
      n = 0;
      while (irq_n !== 1'b0 && n < 100) begin
         wait_n(1);
         n++;
      end
      chk(n < 100, 1'b1, "interrupt wait");
      if (n >= 100) end_sim();
   endtask : wait_irq
   initial begin
      void'($urandom(93));
      repeat (4) @(posedge sys_clk);
      rst <= 1'b0;
      wait_n(1);
      chk({irq_n, first_status_reg}, 32'h8, "after reset");
      @(posedge sys_clk) cfg3 <= 8'h00;
      wait_n(2);
      chk(highpass_filter_on, 1'b0, "filter enable");
      wait_n(30);
      chk(idle_phase_reg, 32'h0, "idle phases");
      chk(pulses > 0, 1'b1, "pulses while loaded");
      $display("test loaded done");
      for (int p = 0; p < 3; p++) begin
         @(posedge sys_clk) load[p] <= 1'b0;
         wait_irq();
         wait_n(20);
         chk(idle_phase_reg, {idle_exp(), 6'h00}, "idle phases");
         chk({irq_n, first_status_reg}, 32'h8, "flag clear");
         $display("test drop phase %0d done", p);
      end
      @(posedge sys_clk) load <= 3'h7;
      wait_irq();
      wait_n(40);
      chk(idle_phase_reg, 32'h0, "idle phases");
      chk({irq_n, first_status_reg}, 32'h8, "flag clear");
      $display("test reload done");
      @(posedge sys_clk) load <= 3'h0;
      wait_n(40);
      chk(pulse_output, 32'h0, "pulses when unloaded");
      @(posedge sys_clk) tb_rd <= 1'b1;
      @(posedge sys_clk) tb_rd <= 1'b0;
      #1;
      for (int k = 0; k < 9; k++) chk(energy_acc[k/3][k%3], 32'h0, "energy after read");
      $display("test read clear done");
      end_sim();
   end
endmodule : energy_noload_detect_tb_top
